/* File: logic/dcp_slave.sv */
// Control port slave: two-wire and four-wire access to RAMs and registers
`timescale 1ns/1ps
module dcp_slave (
	input wire logic clk_sys_in,
	input wire logic rstn_in,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_out,
	input wire logic addr_strap_low_in,
	input wire logic addr_strap_high_in,
	input wire logic latch_or_protect_pin_in,
	input wire logic spi_serial_clock_in,
	input wire logic spi_serial_input_in,
	output logic spi_serial_output_out,
	output logic spi_serial_output_oe_out,
	output logic spi_mode_out,
	output dcp_pkg::dcp_access_t mem_acc_out,
	output logic mem_wr_out,
	output logic mem_rd_out,
	input wire logic [7:0] mem_rdata_in
);
	logic [6:0] pin_f;
	logic scl_f, sda_f, lat_f, sck_f, sdi_f, strap_lo, strap_hi;
	logic [3:0] prev_q;
	logic scl_rise, scl_fall, sck_rise, sck_fall, lat_fall;
	logic i2c_start, i2c_stop;

	dcp_sync #(
		.W(dcp_pkg::PIN_W),
		.INIT(dcp_pkg::PIN_INIT)
	) u_sync (
		.clk_sys_in(clk_sys_in),
		.rstn_in(rstn_in),
		.d_in({scl_in, sda_in, latch_or_protect_pin_in, spi_serial_clock_in,
			spi_serial_input_in, addr_strap_low_in, addr_strap_high_in}),
		.q_out(pin_f)
	);

	assign {scl_f, sda_f, lat_f, sck_f, sdi_f, strap_lo, strap_hi} = pin_f;

	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			// Serial clock idles high; a low reset value gives a false edge
			prev_q <= 4'hF;
		end else begin
			prev_q <= {scl_f, sda_f, lat_f, sck_f};
		end
	end

	assign scl_rise = scl_f & ~prev_q[3];
	assign scl_fall = ~scl_f & prev_q[3];
	assign lat_fall = ~lat_f & prev_q[1];
	assign sck_rise = sck_f & ~prev_q[0];
	assign sck_fall = ~sck_f & prev_q[0];
	// SDA edges only count while SCL stays high across both samples
	assign i2c_start = scl_f & prev_q[3] & prev_q[2] & ~sda_f;
	assign i2c_stop = scl_f & prev_q[3] & ~prev_q[2] & sda_f;

	// Mode select
	logic spi_mode_q;
	logic [1:0] lat_cnt_q;

	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			spi_mode_q <= 1'b0;
			lat_cnt_q <= 2'h0;
		end else if (!spi_mode_q && lat_fall) begin
			// The third low switches mode; while latch stays low the four-wire engine then takes that frame
			if (lat_cnt_q == dcp_pkg::LATCH_FALLS - 2'h1) begin
				spi_mode_q <= 1'b1;
			end
			lat_cnt_q <= lat_cnt_q + 2'h1;
		end
	end
	// No path clears the mode; only rstn_in leaves four-wire operation

	// Shared pointer state
	logic [11:0] addr_q;
	logic [2:0] idx_q;
	logic ovf_q;
	logic [2:0] cur_len;
	logic at_last;
	logic sub_set, ptr_adv, adv_is_rd, wr_ev, rd_ev;
	logic [11:0] new_sub;
	logic [7:0] wr_byte;

	assign cur_len = dcp_pkg::dcp_word_len(addr_q);
	// A gap after a region ends the map just like the highest location
	assign at_last = (addr_q == dcp_pkg::SUB_HIGHEST) ||
		(dcp_pkg::dcp_word_len(addr_q + 12'h001) == 3'h0);

	// Two-wire engine
	dcp_pkg::dcp_state_t st_q;
	dcp_pkg::dcp_kind_t kind_q;
	logic [3:0] cnt_q;
	logic [7:0] sh_q;
	logic [3:0] sub_hi_q;
	logic rw_q, mack_q;
	logic byte_in, addr_match, sub_ok;
	logic i2c_sub, i2c_wr, i2c_rd_adv, i2c_load;

	assign byte_in = (st_q == dcp_pkg::ST_RECV) && scl_fall &&
		(cnt_q == dcp_pkg::BITS_PER_BYTE);
	assign addr_match = (sh_q[7:1] ==
		{dcp_pkg::I2C_ADDR_HI, strap_hi, strap_lo});
	assign sub_ok = dcp_pkg::dcp_word_len({sub_hi_q, sh_q}) != 3'h0;
	assign i2c_sub = byte_in && kind_q == dcp_pkg::BK_SUBL && sub_ok;
	assign i2c_wr = byte_in && kind_q == dcp_pkg::BK_DATA && !ovf_q;
	assign i2c_rd_adv = (st_q == dcp_pkg::ST_MACK) && scl_rise && !sda_f;
	assign i2c_load = ((st_q == dcp_pkg::ST_ACK) && scl_fall &&
		kind_q == dcp_pkg::BK_ADDR && rw_q) ||
		((st_q == dcp_pkg::ST_MACK) && scl_fall && mack_q);

	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			st_q <= dcp_pkg::ST_IDLE;
			kind_q <= dcp_pkg::BK_ADDR;
			cnt_q <= 4'h0;
			sh_q <= 8'h00;
			sub_hi_q <= 4'h0;
			rw_q <= 1'b0;
			mack_q <= 1'b0;
			sda_oe_out <= 1'b0;
		end else if (spi_mode_q) begin
			st_q <= dcp_pkg::ST_IDLE;
			sda_oe_out <= 1'b0;
		end else if (i2c_start) begin
			// A repeated start reopens address reception too
			st_q <= dcp_pkg::ST_RECV;
			kind_q <= dcp_pkg::BK_ADDR;
			cnt_q <= 4'h0;
			sda_oe_out <= 1'b0;
		end else if (i2c_stop) begin
			st_q <= dcp_pkg::ST_IDLE;
			sda_oe_out <= 1'b0;
		end else begin
			unique case (st_q)
			dcp_pkg::ST_IDLE: begin
				sda_oe_out <= 1'b0;
			end
			dcp_pkg::ST_RECV: begin
				if (scl_rise && cnt_q != dcp_pkg::BITS_PER_BYTE) begin
					sh_q <= {sh_q[6:0], sda_f};
					cnt_q <= cnt_q + 4'h1;
				end else if (byte_in) begin
					unique case (kind_q)
					dcp_pkg::BK_ADDR: begin
						if (addr_match) begin
							rw_q <= sh_q[0];
							sda_oe_out <= 1'b1;
							st_q <= dcp_pkg::ST_ACK;
						end else begin
							st_q <= dcp_pkg::ST_IDLE;
						end
					end
					dcp_pkg::BK_SUBH: begin
						sub_hi_q <= sh_q[3:0];
						sda_oe_out <= 1'b1;
						st_q <= dcp_pkg::ST_ACK;
					end
					dcp_pkg::BK_SUBL: begin
						sda_oe_out <= sub_ok;
						st_q <= sub_ok ? dcp_pkg::ST_ACK : dcp_pkg::ST_IDLE;
					end
					dcp_pkg::BK_DATA: begin
						sda_oe_out <= !ovf_q;
						st_q <= ovf_q ? dcp_pkg::ST_IDLE : dcp_pkg::ST_ACK;
					end
					endcase
				end
			end
			dcp_pkg::ST_ACK: begin
				if (scl_fall) begin
					cnt_q <= 4'h0;
					if (i2c_load) begin
						sh_q <= mem_rdata_in;
						sda_oe_out <= ~mem_rdata_in[7];
						cnt_q <= 4'h1;
						st_q <= dcp_pkg::ST_SEND;
					end else begin
						sda_oe_out <= 1'b0;
						st_q <= dcp_pkg::ST_RECV;
						unique case (kind_q)
						dcp_pkg::BK_ADDR: kind_q <= dcp_pkg::BK_SUBH;
						dcp_pkg::BK_SUBH: kind_q <= dcp_pkg::BK_SUBL;
						dcp_pkg::BK_SUBL: kind_q <= dcp_pkg::BK_DATA;
						dcp_pkg::BK_DATA: kind_q <= dcp_pkg::BK_DATA;
						endcase
					end
				end
			end
			dcp_pkg::ST_SEND: begin
				if (scl_fall) begin
					if (cnt_q == dcp_pkg::BITS_PER_BYTE) begin
						sda_oe_out <= 1'b0;
						st_q <= dcp_pkg::ST_MACK;
					end else begin
						sda_oe_out <= ~sh_q[6];
						sh_q <= {sh_q[6:0], 1'b0};
						cnt_q <= cnt_q + 4'h1;
					end
				end
			end
			dcp_pkg::ST_MACK: begin
				if (scl_rise) begin
					mack_q <= ~sda_f;
				end else if (scl_fall) begin
					if (mack_q) begin
						sh_q <= mem_rdata_in;
						sda_oe_out <= ~mem_rdata_in[7];
						cnt_q <= 4'h1;
						st_q <= dcp_pkg::ST_SEND;
					end else begin
						st_q <= dcp_pkg::ST_IDLE;
					end
				end
			end
			endcase
		end
	end

	// Four-wire engine
	logic [2:0] sbit_q;
	logic [1:0] sbyte_q;
	logic [6:0] ssh_q;
	logic [6:0] stx_q;
	logic [3:0] shi_q;
	logic srw_q, sdead_q, spi_live, sbyte_end;
	logic spi_sub, spi_wr, spi_rd_adv, spi_load;

	assign spi_live = spi_mode_q && !lat_f && !sdead_q;
	assign sbyte_end = spi_live && sck_rise && sbit_q == 3'h7;
	assign spi_sub = sbyte_end && sbyte_q == 2'h2 &&
		dcp_pkg::dcp_word_len({shi_q, ssh_q, sdi_f}) != 3'h0;
	assign spi_wr = sbyte_end && sbyte_q == 2'h3 && !srw_q && !ovf_q;
	assign spi_rd_adv = sbyte_end && sbyte_q == 2'h3 && srw_q;
	assign spi_load = spi_live && sck_fall && sbyte_q == 2'h3 && srw_q &&
		sbit_q == 3'h0;

	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			sbit_q <= 3'h0;
			sbyte_q <= 2'h0;
			ssh_q <= 7'h00;
			stx_q <= 7'h00;
			shi_q <= 4'h0;
			srw_q <= 1'b0;
			sdead_q <= 1'b0;
			spi_serial_output_out <= 1'b0;
			spi_serial_output_oe_out <= 1'b0;
		end else if (!spi_mode_q || lat_f) begin
			sbit_q <= 3'h0;
			sbyte_q <= 2'h0;
			sdead_q <= 1'b0;
			spi_serial_output_oe_out <= 1'b0;
		end else if (!sdead_q) begin
			if (sck_rise) begin
				ssh_q <= {ssh_q[5:0], sdi_f};
				sbit_q <= sbit_q + 3'h1;
				if (sbit_q == 3'h7) begin
					if (sbyte_q != 2'h3) begin
						sbyte_q <= sbyte_q + 2'h1;
					end
					unique case (sbyte_q)
					2'h0: begin
						srw_q <= sdi_f;
						sdead_q <= ssh_q !=
							{dcp_pkg::SPI_ADDR_HI, strap_lo};
					end
					2'h1: shi_q <= {ssh_q[2:0], sdi_f};
					2'h2: sdead_q <= !spi_sub;
					2'h3: sdead_q <= spi_wr ? 1'b0 : !srw_q && ovf_q;
					endcase
				end
			end else if (spi_load) begin
				spi_serial_output_oe_out <= 1'b1;
				spi_serial_output_out <= mem_rdata_in[7];
				stx_q <= mem_rdata_in[6:0];
			end else if (sck_fall && spi_serial_output_oe_out) begin
				spi_serial_output_out <= stx_q[6];
				stx_q <= {stx_q[5:0], 1'b0};
			end
		end
	end

	// Pointer and memory side
	assign sub_set = i2c_sub | spi_sub;
	assign new_sub = spi_mode_q ? {shi_q, ssh_q, sdi_f} : {sub_hi_q, sh_q};
	assign wr_ev = i2c_wr | spi_wr;
	assign rd_ev = i2c_load | spi_load;
	assign adv_is_rd = i2c_rd_adv | spi_rd_adv;
	assign ptr_adv = wr_ev | adv_is_rd;
	assign wr_byte = spi_mode_q ? {ssh_q, sdi_f} : sh_q;

	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			addr_q <= 12'h000;
			idx_q <= 3'h0;
			ovf_q <= 1'b0;
		end else if (sub_set) begin
			addr_q <= new_sub;
			idx_q <= 3'h0;
			ovf_q <= 1'b0;
		end else if (ptr_adv) begin
			if (idx_q == cur_len - 3'h1) begin
				idx_q <= 3'h0;
				if (at_last) begin
					ovf_q <= !adv_is_rd;
				end else begin
					addr_q <= addr_q + 12'h001;
				end
			end else begin
				idx_q <= idx_q + 3'h1;
			end
		end
	end

	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			mem_acc_out <= '0;
			mem_wr_out <= 1'b0;
			mem_rd_out <= 1'b0;
			sda_out <= 1'b0;
			spi_mode_out <= 1'b0;
		end else begin
			mem_acc_out.addr <= addr_q;
			mem_acc_out.byte_idx <= idx_q;
			if (wr_ev) begin
				mem_acc_out.data <= wr_byte;
			end
			mem_wr_out <= wr_ev;
			mem_rd_out <= rd_ev;
			sda_out <= 1'b0;
			spi_mode_out <= spi_mode_q;
		end
	end

	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (!rstn_in);

	chk_slave_only_drive: assert property (
		sda_oe_out |-> st_q inside {dcp_pkg::ST_RECV, dcp_pkg::ST_ACK,
			dcp_pkg::ST_SEND})
		else $error("SDA driven outside an answer");
	chk_addr_mismatch: assert property (
		byte_in && kind_q == dcp_pkg::BK_ADDR && !addr_match && !i2c_start
		&& !i2c_stop && !spi_mode_q |=> st_q == dcp_pkg::ST_IDLE
		&& !sda_oe_out)
		else $error("Foreign address not dropped");
	chk_ack_held: assert property (
		st_q == dcp_pkg::ST_ACK && $past(st_q) == dcp_pkg::ST_ACK
		|-> sda_oe_out)
		else $error("Acknowledge not held low");
	chk_stop_idle: assert property (
		i2c_stop && !i2c_start && !spi_mode_q |=> st_q == dcp_pkg::ST_IDLE)
		else $error("Stop did not return to idle");
	chk_bad_sub_nack: assert property (
		byte_in && kind_q == dcp_pkg::BK_SUBL && !sub_ok && !i2c_start
		&& !i2c_stop && !spi_mode_q |=> !sda_oe_out [*2])
		else $error("Invalid subaddress acknowledged");
	chk_write_ovf: assert property (
		byte_in && kind_q == dcp_pkg::BK_DATA && ovf_q && !i2c_start
		&& !i2c_stop && !spi_mode_q |=> st_q == dcp_pkg::ST_IDLE
		##1 !mem_wr_out)
		else $error("Excess write byte taken");
	chk_read_hold: assert property (
		adv_is_rd && !sub_set && at_last && idx_q == cur_len - 3'h1
		|=> addr_q == $past(addr_q) && idx_q == 3'h0)
		else $error("Read moved past highest location");
	chk_spi_sticky: assert property (
		spi_mode_q |=> spi_mode_q [*8])
		else $error("Four-wire mode left without reset");
	chk_three_lows: assert property (
		$rose(spi_mode_q) |-> $past(lat_cnt_q) == 2'h2 && $past(lat_fall))
		else $error("Mode switch not on third low");
	chk_spi_tristate: assert property (
		spi_serial_output_oe_out |-> srw_q && sbyte_q == 2'h3)
		else $error("Serial output driven outside a read");
	chk_word_step: assert property (
		wr_ev && !sub_set && idx_q != cur_len - 3'h1
		|=> idx_q == $past(idx_q) + 3'h1 && addr_q == $past(addr_q))
		else $error("Subaddress moved inside a word");

	cov_i2c_write: cover property (mem_wr_out && !spi_mode_q);
	cov_i2c_read: cover property (mem_rd_out && !spi_mode_q);
	cov_spi_entry: cover property ($rose(spi_mode_q));
	cov_spi_read: cover property ($rose(spi_serial_output_oe_out));
endmodule

/* File: inc/dcp_pkg.sv */
// Shared constants, types and subaddress decode for the control port slave
package dcp_pkg;
	localparam int SUB_W = 12;
	localparam int PIN_W = 7;
	// Fixed upper five bits of the two-wire slave address
	localparam logic [4:0] I2C_ADDR_HI = 5'h0D;
	// Fixed upper six bits of the four-wire chip address
	localparam logic [5:0] SPI_ADDR_HI = 6'h00;
	localparam logic [1:0] LATCH_FALLS = 2'h3;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	// Subaddress map: base, last location and word length in bytes
	localparam logic [11:0] PRAM_BASE = 12'h000;
	localparam logic [11:0] PRAM_LAST = 12'h3FF;
	localparam logic [2:0] PRAM_LEN = 3'h4;
	localparam logic [11:0] PROG_BASE = 12'h400;
	localparam logic [11:0] PROG_LAST = 12'h5FF;
	localparam logic [2:0] PROG_LEN = 3'h5;
	localparam logic [11:0] IFR_BASE = 12'h800;
	localparam logic [11:0] IFR_LAST = 12'h807;
	localparam logic [2:0] IFR_LEN = 3'h4;
	localparam logic [11:0] CREG_BASE = 12'h808;
	localparam logic [11:0] CREG_LAST = 12'h827;
	localparam logic [2:0] CREG_LEN = 3'h2;
	localparam logic [11:0] SUB_HIGHEST = CREG_LAST;
	// Idle pin levels {scl, sda, latch, sclk, sdi, strap_lo, strap_hi}
	localparam logic [6:0] PIN_INIT = 7'h78;

	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_RECV = 5'h02,
		ST_ACK  = 5'h04,
		ST_SEND = 5'h08,
		ST_MACK = 5'h10
	} dcp_state_t;

	typedef enum logic [3:0] {
		BK_ADDR = 4'h1,
		BK_SUBH = 4'h2,
		BK_SUBL = 4'h4,
		BK_DATA = 4'h8
	} dcp_kind_t;

	typedef struct packed {
		logic [11:0] addr;
		logic [2:0] byte_idx;
		logic [7:0] data;
	} dcp_access_t;

	// Word length of a location; zero marks an invalid subaddress
	function automatic logic [2:0] dcp_word_len(input logic [11:0] a);
		if (a <= PRAM_LAST) begin
			return PRAM_LEN;
		end else if (a >= PROG_BASE && a <= PROG_LAST) begin
			return PROG_LEN;
		end else if (a >= IFR_BASE && a <= IFR_LAST) begin
			return IFR_LEN;
		end else if (a >= CREG_BASE && a <= CREG_LAST) begin
			return CREG_LEN;
		end
		return 3'h0;
	endfunction
endpackage

/* File: logic/dcp_sync.sv */
// Three-stage pin synchroniser that accepts a change once stages agree
`timescale 1ns/1ps
module dcp_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input wire logic clk_sys_in,
	input wire logic rstn_in,
	input wire logic [W-1:0] d_in,
	output logic [W-1:0] q_out
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;

	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			s1_q <= INIT;
			s2_q <= INIT;
			s3_q <= INIT;
			q_out <= INIT;
		end else begin
			s1_q <= d_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
			// Per bit: take the new level only where two stages agree
			q_out <= (s2_q & s3_q) | (q_out & (s2_q ^ s3_q));
		end
	end
endmodule

/* File: verif/dcp_host.sv */
// Host master model for the two-wire and four-wire control pins
`timescale 1ns/1ps
module dcp_host (
	input wire logic clk_in,
	input wire logic pin_in,
	output logic clk_pin_out,
	output logic din_out,
	output logic latch_out,
	output logic pull_out
);
	initial begin
		clk_pin_out = 1'b1;
		din_out = 1'b0;
		latch_out = 1'b1;
		pull_out = 1'b0;
	end
	// Quarter bit of 40 ns, changes land on falling system clock edges
	task automatic q(input int n);
		repeat (n * 10) @(negedge clk_in);
	endtask
	task automatic set_din(input logic v);
		din_out = v;
		q(1);
	endtask
	// Start and repeated start alike; data falls with clock high
	task automatic start();
		pull_out = 1'b0;
		q(1);
		clk_pin_out = 1'b1;
		q(1);
		pull_out = 1'b1;
		q(1);
		clk_pin_out = 1'b0;
		q(1);
	endtask
	task automatic stop();
		pull_out = 1'b1;
		q(1);
		clk_pin_out = 1'b1;
		q(1);
		pull_out = 1'b0;
		q(1);
	endtask
	// Data changes only while the clock is low
	task automatic bit_io(input logic b, output logic got);
		pull_out = ~b;
		q(1);
		clk_pin_out = 1'b1;
		q(1);
		got = pin_in;
		q(1);
		clk_pin_out = 1'b0;
		q(1);
	endtask
	task automatic byte_tx(input logic [7:0] b, output logic ack);
		logic g;
		for (int i = 7; i >= 0; i--) begin
			bit_io(b[i], g);
		end
		bit_io(1'b1, g);
		ack = ~g;
	endtask
	task automatic byte_rx(input logic more, output logic [7:0] b);
		logic g;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, g);
			b[i] = g;
		end
		bit_io(~more, g);
	endtask
	// Latch low opens a frame, high closes it
	task automatic spi_sel(input logic v);
		latch_out = v;
		q(2);
	endtask
	// Clock idles high; data set at the fall, taken back at the rise
	task automatic spi_byte(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			clk_pin_out = 1'b0;
			din_out = tx[i];
			q(2);
			clk_pin_out = 1'b1;
			rx[i] = pin_in;
			q(2);
		end
	endtask
endmodule

/* File: verif/dcp_slave_tb_top.sv */
// Self-checking bench for the control port slave
`timescale 1ns/1ps
module dcp_slave_tb_top;
	logic clk_sys_in = 1'b0;
	logic rstn_in = 1'b0;
	logic strap_low = 1'b0;
	logic use_spi = 1'b0;
	logic [7:0] addr_w = 8'h68;
	logic [7:0] mem_rdata;
	logic [31:0] rng = 32'h44D9E9A2;
	wire clk_pin;
	wire din;
	wire latch;
	wire pull;
	tri1 pin;
	logic sda_out;
	logic sda_oe;
	logic spi_out;
	logic spi_oe;
	logic spi_mode;
	logic mem_wr;
	logic mem_rd;
	dcp_pkg::dcp_access_t acc;
	dcp_pkg::dcp_access_t exp_q[$];
	int fails = 0;
	int check_count = 0;

	always #2 clk_sys_in = ~clk_sys_in;
	// Shared data pin: open drain, four-wire output, host pull-down
	assign pin = sda_oe ? sda_out : 1'bz;
	assign pin = spi_oe ? spi_out : 1'bz;
	assign pin = pull ? 1'b0 : 1'bz;
	// Memory answers a byte derived from its location
	assign mem_rdata = {acc.addr[4:0], acc.byte_idx};

	dcp_slave dcp_slave_inst (
		.clk_sys_in(clk_sys_in),
		.rstn_in(rstn_in),
		.scl_in(clk_pin),
		.sda_in(pin),
		.sda_out(sda_out),
		.sda_oe_out(sda_oe),
		.addr_strap_low_in(strap_low),
		.addr_strap_high_in(din),
		.latch_or_protect_pin_in(latch),
		.spi_serial_clock_in(clk_pin),
		.spi_serial_input_in(din),
		.spi_serial_output_out(spi_out),
		.spi_serial_output_oe_out(spi_oe),
		.spi_mode_out(spi_mode),
		.mem_acc_out(acc),
		.mem_wr_out(mem_wr),
		.mem_rd_out(mem_rd),
		.mem_rdata_in(mem_rdata)
	);
	dcp_host dcp_host_inst (
		.clk_in(clk_sys_in),
		.pin_in(pin),
		.clk_pin_out(clk_pin),
		.din_out(din),
		.latch_out(latch),
		.pull_out(pull)
	);

	function automatic logic [7:0] rnd();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng[7:0];
	endfunction
	task automatic check(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic open_t();
		if (use_spi) dcp_host_inst.spi_sel(1'b0);
		else dcp_host_inst.start();
	endtask
	task automatic close_t();
		if (use_spi) dcp_host_inst.spi_sel(1'b1);
		else dcp_host_inst.stop();
	endtask
	task automatic put(input logic [7:0] b, input logic ack);
		logic g;
		logic [7:0] r;
		if (use_spi) begin
			dcp_host_inst.spi_byte(b, r);
		end else begin
			dcp_host_inst.byte_tx(b, g);
			check("ack", g, ack);
		end
	endtask
	task automatic get(input logic more, output logic [7:0] b);
		if (use_spi) dcp_host_inst.spi_byte(8'h00, b);
		else dcp_host_inst.byte_rx(more, b);
	endtask
	// Leaves the frame open so callers can push past the end
	task automatic wr_burst(input logic [11:0] sub, input int len,
		input int n);
		dcp_pkg::dcp_access_t e;
		open_t();
		put(addr_w, 1'b1);
		put({4'h0, sub[11:8]}, 1'b1);
		put(sub[7:0], 1'b1);
		for (int k = 0; k < n; k++) begin
			e = {sub + 12'(k / len), 3'(k % len), rnd()};
			exp_q.push_back(e);
			put(e.data, 1'b1);
		end
	endtask
	task automatic rd_burst(input logic [11:0] sub, input int len,
		input int n);
		logic [7:0] b;
		logic [11:0] a;
		open_t();
		put(addr_w | {7'h00, use_spi}, 1'b1);
		put({4'h0, sub[11:8]}, 1'b1);
		put(sub[7:0], 1'b1);
		if (!use_spi) begin
			dcp_host_inst.start();
			put(addr_w | 8'h01, 1'b1);
		end
		check("out enable", spi_oe, 1'b0);
		for (int k = 0; k < n; k++) begin
			a = sub + 12'(k / len);
			if (a > dcp_pkg::SUB_HIGHEST) a = dcp_pkg::SUB_HIGHEST;
			get(k < n - 1, b);
			check("read data", b, {a[4:0], 3'(k % len)});
		end
		close_t();
		$display("test read %h done", sub);
	endtask

	// Each write pulse takes the oldest noted write
	// Sampled off the launching edge so the pulse has settled
	always @(negedge clk_sys_in) begin
		if (mem_wr === 1'b1) begin
			if (exp_q.size() == 0) begin
				check("stray write", 32'h1, 32'h0);
			end else begin
				check("write", 32'(acc), 32'(exp_q.pop_front()));
			end
		end
	end

	initial begin
		repeat (90000) @(posedge clk_sys_in);
		fails++;
		test_done();
	end

	initial begin
		repeat (5) @(negedge clk_sys_in);
		rstn_in = 1'b1;
		repeat (8) @(negedge clk_sys_in);
		for (int s = 0; s < 4; s++) begin
			strap_low = s[0];
			dcp_host_inst.set_din(s[1]);
			addr_w = 8'h68 | 8'(s << 1);
			open_t();
			put(addr_w, 1'b1);
			close_t();
			open_t();
			put(addr_w ^ 8'h04, 1'b0);
			put(8'h00, 1'b0);
			close_t();
		end
		$display("test address done");
		wr_burst(12'h808, 2, 4);
		close_t();
		wr_burst(12'h400, 5, 6);
		close_t();
		wr_burst(12'h826, 2, 4);
		put(8'h5A, 1'b0);
		put(8'hA5, 1'b0);
		close_t();
		open_t();
		put(addr_w, 1'b1);
		put(8'h06, 1'b1);
		put(8'h00, 1'b0);
		put(8'h00, 1'b0);
		close_t();
		open_t();
		put(addr_w, 1'b1);
		put(8'h08, 1'b1);
		wr_burst(12'h820, 2, 2);
		close_t();
		$display("test write done");
		rd_burst(12'h010, 4, 5);
		rd_burst(12'h826, 2, 6);
		repeat (3) begin
			dcp_host_inst.spi_sel(1'b0);
			dcp_host_inst.spi_sel(1'b1);
		end
		check("mode", spi_mode, 1'b1);
		use_spi = 1'b1;
		addr_w = 8'h02;
		wr_burst(12'h004, 4, 5);
		close_t();
		rd_burst(12'h827, 2, 3);
		open_t();
		put(8'h00, 1'b1);
		put(8'h08, 1'b1);
		put(8'h10, 1'b1);
		put(8'h01, 1'b1);
		close_t();
		check("out enable", spi_oe, 1'b0);
		check("mode", spi_mode, 1'b1);
		$display("test four wire done");
		rstn_in = 1'b0;
		repeat (3) @(negedge clk_sys_in);
		rstn_in = 1'b1;
		repeat (2) @(negedge clk_sys_in);
		check("mode", spi_mode, 1'b0);
		check("pending writes", exp_q.size(), 0);
		test_done();
	end
endmodule
